//--- hw/tdmpc_pkg.sv
package tdmpc_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int RST_MIN_NS = 100;
    localparam int RST_MIN_CYC = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int FRAME_US = 125;
    localparam int FRAME_CYC = FRAME_US * (CLK_HZ / 1_000_000);
    localparam logic [14:0] PH_MOD = 15'(CLK_HZ / 1000);
    localparam logic [14:0] INC_2M = 15'h0800;
    localparam logic [14:0] INC_4M = 15'h1000;
    localparam logic [14:0] INC_8M = 15'h2000;
    localparam logic [1:0] RATE_2M = 2'h0;
    localparam logic [1:0] RATE_4M = 2'h1;
    localparam logic [1:0] CFG_16X8 = 2'h1;
    localparam logic [1:0] CFG_PAIR = 2'h2;
    localparam logic [13:0] ADR_CTRL = 14'h0000;
    localparam logic [13:0] ADR_STAT = 14'h0004;
    localparam int TBL_BIT = 13;
    localparam int CTL_RATE = 0;
    localparam int CTL_CFG = 2;
    localparam int CTL_PIN = 4;
    localparam int CTL_POUT = 8;
    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam int TB_HIZ = 8;
    localparam int TB_CST = 9;
    localparam int TB_MSG = 10;
    localparam int TB_CDL = 11;
    localparam logic [4:0] IDLE_RUN = 5'h10;
endpackage : tdmpc_pkg

//--- hw/tdmpc_top.sv
`timescale 1ns/1ps
// Contract
// - Shared pin six is address six at high rates on the non-multiplexed bus
// - Frames hold 32, 64 or 128 channels
// - Drive enable low floats all ten outputs
// - Per-channel high-impedance bit floats that channel
// - Control output: 2.048 rate, 256 table bits
// - Multiplexed mode latches address on strobe fall
// - Bus mode pin high selects multiplexed bus
// - Pins 14/15 input or outputs 8/9
// - Every frame lasts 125 microseconds
// - Per-channel constant or minimum delay select
// - Frame pulse polarity detected automatically
// - Message mode sends table byte per channel
// - Sixteen by eight configuration supported
// - Stream pair selection for internal matrix
// - Reset clears state and floats outputs
module tdmpc_top #(
    parameter int N_STREAMS = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic all_output_drive_enable_i,
    input wire logic cpu_bus_mode_select_i,
    input wire logic address_latch_strobe_i,
    input wire logic frame_pulse_i,
    input wire logic [7:0] cpu_ad_i,
    input wire logic [9:0] sw_bit_i,
    output logic [5:0] serial_outputs_low_group_o,
    output logic [5:0] serial_outputs_low_group_oe_o,
    input wire logic out6_addr6_shared_pin_i,
    output logic out6_addr6_shared_pin_o,
    output logic out6_addr6_shared_pin_oe_o,
    output logic stream7_out_o,
    output logic stream7_out_oe_o,
    input wire logic in14_out8_shared_pin_i,
    output logic in14_out8_shared_pin_o,
    output logic in14_out8_shared_pin_oe_o,
    input wire logic in15_out9_shared_pin_i,
    output logic in15_out9_shared_pin_o,
    output logic in15_out9_shared_pin_oe_o,
    output logic control_serial_output_o,
    output logic [7:0] latched_addr_o,
    output logic cpu_addr6_o,
    output logic cpu_mux_mode_o,
    output logic gci_format_o,
    output logic [1:0] rate_sel_o,
    output logic sixteen_in_mode_o,
    output logic pair_sel_en_o,
    output logic [3:0] pair_in_o,
    output logic [3:0] pair_out_o,
    output logic [9:0] const_delay_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [14:0] s1_r, s2_r;
    logic fr_d_r, strb_d_r;
    logic ode_s, im_s, strb_s, fr_s, o6_s;
    logic [7:0] ad_s;

    always_ff @(posedge clk_i)
    begin
        s1_r <= {cpu_ad_i, in15_out9_shared_pin_i, in14_out8_shared_pin_i, out6_addr6_shared_pin_i,
                 frame_pulse_i, address_latch_strobe_i, cpu_bus_mode_select_i, all_output_drive_enable_i};
        s2_r <= s1_r;
        fr_d_r <= s2_r[3];
        strb_d_r <= s2_r[2];
    end

    assign ode_s = s2_r[0];
    assign im_s = s2_r[1];
    assign strb_s = s2_r[2];
    assign fr_s = s2_r[3];
    assign o6_s = s2_r[4];
    assign ad_s = s2_r[14:7];

    ////////////////////////////////////////////////////////////////////////////
    logic [11:0] ctrl_r;
    logic [11:0] tbl_r [0:2047];
    logic [1:0] cfg;
    logic addr6_mode, s89_out;
    logic [7:0] lat_r;
    logic gci_r;

    assign rate_sel_o = ctrl_r[tdmpc_pkg::CTL_RATE +: 2];
    assign cfg = ctrl_r[tdmpc_pkg::CTL_CFG +: 2];
    assign pair_in_o = ctrl_r[tdmpc_pkg::CTL_PIN +: 4];
    assign pair_out_o = ctrl_r[tdmpc_pkg::CTL_POUT +: 4];
    assign addr6_mode = ~im_s & (rate_sel_o != tdmpc_pkg::RATE_2M);
    assign s89_out = im_s & pair_sel_en_o;
    assign cpu_mux_mode_o = s2_r[1];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl_r <= tdmpc_pkg::CTRL_RST;
            sixteen_in_mode_o <= 1'b0;
            pair_sel_en_o <= 1'b0;
            for (int i = 0; i < 2048; i++)
                tbl_r[i] <= 12'h000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            sixteen_in_mode_o <= (cfg == tdmpc_pkg::CFG_16X8);
            pair_sel_en_o <= (cfg == tdmpc_pkg::CFG_PAIR);
            if (wb_cyc_i & wb_stb_i & ~wb_ack_o)
            begin
                if (wb_we_i)
                begin
                    if (wb_adr_i[tdmpc_pkg::TBL_BIT])
                    begin
                        if (wb_sel_i[0])
                            tbl_r[wb_adr_i[12:2]][7:0] <= wb_dat_i[7:0];
                        if (wb_sel_i[1])
                            tbl_r[wb_adr_i[12:2]][11:8] <= wb_dat_i[11:8];
                    end
                    else if (wb_adr_i == tdmpc_pkg::ADR_CTRL)
                    begin
                        if (wb_sel_i[0])
                            ctrl_r[7:0] <= wb_dat_i[7:0];
                        if (wb_sel_i[1])
                            ctrl_r[11:8] <= wb_dat_i[11:8];
                    end
                end
                else if (wb_adr_i[tdmpc_pkg::TBL_BIT])
                    wb_dat_o <= {20'h00000, tbl_r[wb_adr_i[12:2]]};
                else if (wb_adr_i == tdmpc_pkg::ADR_CTRL)
                    wb_dat_o <= {20'h00000, ctrl_r};
                else if (wb_adr_i == tdmpc_pkg::ADR_STAT)
                    wb_dat_o <= {16'h0000, lat_r, 4'h0, addr6_mode, ode_s, gci_r, im_s};
                else
                    wb_dat_o <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The idle level of the frame input is learnt from long steady runs; a
    // pulse is the departure from that level.
    logic [4:0] run_r;
    logic idle_r, frame_start;

    assign frame_start = (fr_s != idle_r) && (fr_d_r == idle_r);
    assign gci_format_o = gci_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run_r <= 5'h00;
            idle_r <= 1'b1;
            gci_r <= 1'b0;
        end
        else
        begin
            if (fr_s != fr_d_r)
                run_r <= 5'h00;
            else if (run_r != tdmpc_pkg::IDLE_RUN)
                run_r <= run_r + 5'h01;
            if ((run_r == tdmpc_pkg::IDLE_RUN) && (fr_s == fr_d_r))
            begin
                idle_r <= fr_s;
                gci_r <= ~fr_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // A phase accumulator modulo the clock rate in kHz yields exact bit rates,
    // so a frame always spans the same number of clock cycles.
    logic [14:0] inc, acc_r, cacc_r, sum, csum;
    logic [9:0] bitc_r, last;
    logic [7:0] cbit_r;
    logic tick, ctick;

    assign inc = (rate_sel_o == tdmpc_pkg::RATE_2M) ? tdmpc_pkg::INC_2M :
                 (rate_sel_o == tdmpc_pkg::RATE_4M) ? tdmpc_pkg::INC_4M : tdmpc_pkg::INC_8M;
    assign last = 10'(int'(inc) * tdmpc_pkg::FRAME_US / 1000 - 1);
    assign sum = acc_r + inc;
    assign csum = cacc_r + tdmpc_pkg::INC_2M;
    assign tick = sum >= tdmpc_pkg::PH_MOD;
    assign ctick = csum >= tdmpc_pkg::PH_MOD;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || frame_start)
        begin
            acc_r <= 15'h0000;
            cacc_r <= 15'h0000;
            bitc_r <= 10'h000;
            cbit_r <= 8'h00;
        end
        else
        begin
            acc_r <= tick ? sum - tdmpc_pkg::PH_MOD : sum;
            cacc_r <= ctick ? csum - tdmpc_pkg::PH_MOD : csum;
            if (tick)
                bitc_r <= (bitc_r == last) ? 10'h000 : bitc_r + 10'h001;
            if (ctick)
                cbit_r <= cbit_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [9:0] so_r, oe_r, pin_out, hiz_v, msg_v;
    logic cst_r, a6_r;

    genvar s;
    generate
        for (s = 0; s < N_STREAMS; s++)
        begin : g_str
            logic [11:0] ent;
            assign ent = tbl_r[{4'(s), bitc_r[9:3]}];
            assign hiz_v[s] = ent[tdmpc_pkg::TB_HIZ];
            assign msg_v[s] = ent[tdmpc_pkg::TB_MSG];
            assign pin_out[s] = (s == 6) ? ~addr6_mode : (s >= 8) ? s89_out : 1'b1;
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    so_r[s] <= 1'b0;
                    oe_r[s] <= 1'b0;
                    const_delay_o[s] <= 1'b0;
                end
                else
                begin
                    oe_r[s] <= ode_s & ~ent[tdmpc_pkg::TB_HIZ] & pin_out[s];
                    if (tick)
                    begin
                        so_r[s] <= ent[tdmpc_pkg::TB_MSG] ? ent[~bitc_r[2:0]] : sw_bit_i[s];
                        const_delay_o[s] <= ent[tdmpc_pkg::TB_CDL];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cst_r <= 1'b0;
            lat_r <= 8'h00;
            a6_r <= 1'b0;
        end
        else
        begin
            if (ctick)
                cst_r <= tbl_r[{1'b0, cbit_r[7:5], 2'b00, cbit_r[4:0]}][tdmpc_pkg::TB_CST];
            if (im_s & strb_d_r & ~strb_s)
                lat_r <= ad_s;
            a6_r <= addr6_mode & o6_s;
        end
    end

    assign serial_outputs_low_group_o = so_r[5:0];
    assign serial_outputs_low_group_oe_o = oe_r[5:0];
    assign out6_addr6_shared_pin_o = so_r[6];
    assign out6_addr6_shared_pin_oe_o = oe_r[6];
    assign stream7_out_o = so_r[7];
    assign stream7_out_oe_o = oe_r[7];
    assign in14_out8_shared_pin_o = so_r[8];
    assign in14_out8_shared_pin_oe_o = oe_r[8];
    assign in15_out9_shared_pin_o = so_r[9];
    assign in15_out9_shared_pin_oe_o = oe_r[9];
    assign control_serial_output_o = cst_r;
    assign latched_addr_o = lat_r;
    assign cpu_addr6_o = a6_r;

    ////////////////////////////////////////////////////////////////////////////
    logic [10:0] fcyc_r;
    logic [1:0] rate_d_r;
    logic rate_chg_r;

    // A rate change inside a frame makes that frame's length meaningless.
    always_ff @(posedge clk_i)
    begin
        rate_d_r <= rate_sel_o;
        if (rst_i || frame_start || (tick && bitc_r == last))
        begin
            fcyc_r <= 11'h000;
            rate_chg_r <= 1'b0;
        end
        else
        begin
            fcyc_r <= fcyc_r + 11'h001;
            rate_chg_r <= rate_chg_r | (rate_d_r != rate_sel_o);
        end
    end

    a_ode_off_hiz: assert property (@(posedge clk_i) disable iff (rst_i) !ode_s |=> oe_r == 10'h000)
        else $error("output enabled while drive enable low");
    a_chan_hiz_bit: assert property (@(posedge clk_i) disable iff (rst_i) hiz_v[0] |=> !oe_r[0])
        else $error("channel set high impedance was driven");
    a_addr6_no_drive: assert property (@(posedge clk_i) disable iff (rst_i) addr6_mode |=> !oe_r[6])
        else $error("address pin six driven");
    a_pins89_input: assert property (@(posedge clk_i) disable iff (rst_i) !s89_out |=> oe_r[9:8] == 2'b00)
        else $error("pins 14/15 driven while input");
    a_reset_floats: assert property (@(posedge clk_i) rst_i |=> oe_r == 10'h000 && !cst_r)
        else $error("outputs active after reset");
    a_latch_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        im_s && strb_d_r && !strb_s |=> lat_r == $past(ad_s))
        else $error("address not latched on strobe fall");
    a_frame_period: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && bitc_r == last && !rate_chg_r && $past(ctrl_r) == ctrl_r |-> fcyc_r == 11'(tdmpc_pkg::FRAME_CYC - 1))
        else $error("frame length wrong");
    a_msg_bit_out: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && msg_v[2] |=> so_r[2] == $past(tbl_r[{4'h2, bitc_r[9:3]}][~bitc_r[2:0]]))
        else $error("message bit wrong");
    a_mux_pins_out: assert property (@(posedge clk_i) disable iff (rst_i)
        s89_out && ode_s && !hiz_v[8] |=> oe_r[8])
        else $error("stream 8 not driven");

    c_frame_wrap: cover property (@(posedge clk_i) disable iff (rst_i) tick && bitc_r == last);
    c_latch: cover property (@(posedge clk_i) disable iff (rst_i) im_s && strb_d_r && !strb_s);
    c_gci: cover property (@(posedge clk_i) disable iff (rst_i) $rose(gci_r));
    c_pair_drive: cover property (@(posedge clk_i) disable iff (rst_i) oe_r[9]);
endmodule : tdmpc_top

//--- dv/tdmpc_peer.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tdmpc_peer (
    input wire logic clk_i,
    input wire logic pol_i,
    input wire logic mux_i,
    input wire logic [2:0] pin_o_i,
    input wire logic [2:0] pin_oe_i,
    output logic [2:0] pin_lvl_o,
    output logic frame_pulse_o,
    output logic [9:0] sw_bit_o
);
    int cnt = 0;

    initial frame_pulse_o = 1'b1;

    // A two-cycle frame pulse is sent at the start of every frame.
    always @(posedge clk_i)
    begin
        cnt <= (cnt == tdmpc_pkg::FRAME_CYC - 1) ? 0 : cnt + 1;
        frame_pulse_o <= (cnt < 2) ? pol_i : !pol_i;
    end

    assign sw_bit_o = 10'h000;
    // The host holds address six high whenever the pin is released.
    assign pin_lvl_o[0] = pin_oe_i[0] ? pin_o_i[0] : 1'b1;
    // Pins 14 and 15 carry an input stream only on the multiplexed bus and are grounded otherwise.
    assign pin_lvl_o[1] = pin_oe_i[1] ? pin_o_i[1] : (mux_i & cnt[0]);
    assign pin_lvl_o[2] = pin_oe_i[2] ? pin_o_i[2] : (mux_i & ~cnt[0]);
endmodule : tdmpc_peer

//--- dv/tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [13:0] adr = 14'h0000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] sel = 4'h0;
    logic we = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic all_output_drive_enable = 1'b0, mux = 1'b0, pol = 1'b0;
    logic ale = 1'b0;
    logic [7:0] cad = 8'h00;
    logic [31:0] rdat, q;
    logic ack, fp, cst, a6, mm, gci, p6o, p6e, p7o, p7e, p8o, p8e, p9o, p9e;
    logic [5:0] lo_o, lo_e;
    logic [2:0] lvl;
    logic [9:0] swb, cdl;
    logic [7:0] la;
    logic m16, pse;
    logic [1:0] rs;
    logic [3:0] pi, po;
    int bad_count = 0, num_checks = 0;
    int n0, n1, nc, nd, n6, n8, nm, ncd, e;

    always #50 clk_i = ~clk_i;

    tdmpc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .all_output_drive_enable_i(all_output_drive_enable), .cpu_bus_mode_select_i(mux), .address_latch_strobe_i(ale),
        .frame_pulse_i(fp), .cpu_ad_i(cad), .sw_bit_i(swb), .serial_outputs_low_group_o(lo_o),
        .serial_outputs_low_group_oe_o(lo_e), .out6_addr6_shared_pin_i(lvl[0]), .out6_addr6_shared_pin_o(p6o),
        .out6_addr6_shared_pin_oe_o(p6e), .stream7_out_o(p7o), .stream7_out_oe_o(p7e),
        .in14_out8_shared_pin_i(lvl[1]), .in14_out8_shared_pin_o(p8o), .in14_out8_shared_pin_oe_o(p8e),
        .in15_out9_shared_pin_i(lvl[2]), .in15_out9_shared_pin_o(p9o), .in15_out9_shared_pin_oe_o(p9e),
        .control_serial_output_o(cst), .latched_addr_o(la), .cpu_addr6_o(a6), .cpu_mux_mode_o(mm),
        .gci_format_o(gci), .rate_sel_o(rs), .sixteen_in_mode_o(m16), .pair_sel_en_o(pse), .pair_in_o(pi),
        .pair_out_o(po), .const_delay_o(cdl));

    tdmpc_peer peer (.clk_i(clk_i), .pol_i(pol), .mux_i(mux), .pin_o_i({p9o, p8o, p6o}),
        .pin_oe_i({p9e, p8e, p6e}), .pin_lvl_o(lvl), .frame_pulse_o(fp), .sw_bit_o(swb));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One classic Wishbone cycle, held until acknowledge is sampled high.
    task automatic wb(input logic [13:0] a, input logic w, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        we <= w;
        sel <= 4'h3;
        cyc <= 1'b1;
        stb <= 1'b1;
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // Counts output activity over one whole frame, starting at the frame pulse.
    task automatic watch;
        repeat (4) @(posedge clk_i);
        while (fp !== pol)
        begin
            @(posedge clk_i);
        end
        {n0, n1, nc, nd, n6, n8, nm, ncd} = '0;
        repeat (tdmpc_pkg::FRAME_CYC)
        begin
            @(posedge clk_i);
            n0 += int'(lo_e[0] === 1'b0);
            n1 += int'(lo_e[1] === 1'b0);
            nc += int'(cst === 1'b1);
            nd += int'(|{lo_e, p6e, p7e, p8e, p9e} !== 1'b0);
            n6 += int'(p6e === 1'b1);
            n8 += int'({p8e, p9e} === 2'b11);
            nm += int'(lo_o[2] === 1'b1);
            ncd += int'(cdl[0] === 1'b1);
        end
    endtask : watch

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(100 * 40000);
        bad_count++;
        final_report();
    end

    initial
    begin
        repeat (8) @(posedge clk_i);
        chk(32'({lo_e, p6e, p7e, p8e, p9e}), 0);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(tdmpc_pkg::ADR_CTRL, 1'b0, 0);
        chk(q, 0);
        wb(14'h0100, 1'b1, 32'h0000_00FF);
        wb(14'h0100, 1'b0, 0);
        chk(q, 0);
        // Stream 0 channel 0 floats, carries the control bit and constant delay; stream 2 channel 0 sends a message.
        wb(14'h2000, 1'b1, 32'h0000_0B00);
        wb(14'h2400, 1'b1, 32'h0000_04F0);
        all_output_drive_enable <= 1'b1;
        for (int r = 0; r < 3; r++)
        begin
            wb(tdmpc_pkg::ADR_CTRL, 1'b1, r);
            wb(tdmpc_pkg::ADR_CTRL, 1'b0, 0);
            chk(q, r);
            chk(32'(rs), r);
            watch();
            e = tdmpc_pkg::FRAME_CYC >> (5 + r);
            chk(32'(n0 >= e - 3 && n0 <= e + 3), 1);
            chk(n1, 0);
            chk(32'(nc >= 3 && nc <= 7), 1);
            chk(32'(ncd >= e - 3 && ncd <= e + 3), 1);
            chk(32'(nm >= e / 2 - 3 && nm <= e / 2 + 3), 1);
            chk(n6, (r == 0) ? tdmpc_pkg::FRAME_CYC : 0);
            chk(32'(a6), 32'(r != 0));
            chk(n8, 0);
        end
        all_output_drive_enable <= 1'b0;
        watch();
        chk(nd, 0);
        all_output_drive_enable <= 1'b1;
        mux <= 1'b1;
        wb(tdmpc_pkg::ADR_CTRL, 1'b1, 32'h0000_0738);
        watch();
        chk(n8, tdmpc_pkg::FRAME_CYC);
        chk(32'(mm), 1);
        chk(32'({m16, pse, po, pi}), 32'h0000_0173);
        wb(tdmpc_pkg::ADR_CTRL, 1'b1, 32'h0000_0004);
        watch();
        chk(n8, 0);
        chk(32'({m16, pse, po, pi}), 32'h0000_0200);
        cad <= 8'hA5;
        ale <= 1'b1;
        repeat (4) @(posedge clk_i);
        ale <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(32'(la), 32'h0000_00A5);
        wb(tdmpc_pkg::ADR_STAT, 1'b0, 0);
        chk(32'(q[15:0]), 32'h0000_A505);
        pol <= 1'b1;
        repeat (2) watch();
        chk(32'(gci), 1);
        final_report();
    end
endmodule : tb_top
